/* design/dti_regs.vh */
`ifndef DTI_REGS_VH
`define DTI_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DTI_OFF_SEL_RXA   4'h0
`define DTI_OFF_SEL_TXA   4'h1
`define DTI_OFF_SEL_RXB   4'h2
`define DTI_OFF_SEL_TXB   4'h3
`define DTI_OFF_AUX       4'h4
`define DTI_OFF_IRQ       4'h5
`define DTI_OFF_PRE_HI    4'h6
`define DTI_OFF_PRE_LO    4'h7
`define DTI_OFF_CMD       4'h8
`define DTI_OFF_CHG       4'h9
`define DTI_OFF_OPCFG     4'ha
`define DTI_OFF_INPORT    4'hd
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define DTI_AUX_EXT_BIT   6
`define DTI_CT_TIMER      2'h1
`define DTI_CMD_START     8'h01
`define DTI_CMD_STOP      8'h02
`define DTI_CMD_LOAD      8'h03
`define DTI_CMD_TO_ON     8'h04
`define DTI_CMD_TO_OFF    8'h05
`define DTI_SEL_RATES     5'h12
`define DTI_SEL_CT        5'h12
`define DTI_SEL_EXT       5'h13
`define DTI_INPORT_TOP    1'h1
// ----------------------------------------
// reset values
// ----------------------------------------
`define DTI_RST_SEL       5'h00
`define DTI_RST_BYTE      8'h00
`define DTI_RST_PRESET    16'h0000
`define DTI_RST_SYNC      27'h380_07f0
// ----------------------------------------
// timing
// ----------------------------------------
`define DTI_OSC_HZ        32'h0038_4000
`define DTI_BAUD_MULT     32'h0000_0010
`define DTI_CHG_HZ        32'h0000_9600
`define DTI_CHG_DIV       (`DTI_OSC_HZ / `DTI_CHG_HZ)
`endif

/* design/dti_ct.v */
`timescale 1ns/1ps
`include "dti_regs.vh"

// 16-bit down counter; reloads from the preset at every zero pass
module dti_ct (
  input  wire        core_clk,   // system clock
  input  wire        rst_b,      // async reset, active low
  input  wire        tick,       // one count step
  input  wire [1:0]  mode,       // counter or timer
  input  wire        to_mode,    // receiver-driven time-out mode
  input  wire [15:0] preset,     // reload value
  input  wire        cmd_start,  // start command
  input  wire        cmd_stop,   // stop command
  input  wire        cmd_load,   // load preset now
  input  wire        rx_start,   // receiver restart request
  input  wire        rx_stop,    // receiver stop request
  output reg  [15:0] count_r,    // current value
  output reg         zero_r,     // pulse at each zero pass
  output reg         sq_r        // square wave output
);
  reg  run_r;
  wire timer     = (mode == `DTI_CT_TIMER) & ~to_mode;
  wire start_any = cmd_start | (to_mode & rx_start); // R14
  wire stop_any  = cmd_stop | (to_mode & rx_stop);   // R14

  // one process: load, start, stop, then counting
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= `DTI_RST_PRESET;
      zero_r  <= 1'b0;
      sq_r    <= 1'b0;
      run_r   <= 1'b0;
    end else begin
      zero_r <= 1'b0;
      if (cmd_load) begin
        count_r <= preset; // R12
      end else if (start_any) begin
        count_r <= preset;
        run_r   <= 1'b1;
      end else if (stop_any) begin
        run_r <= 1'b0;
      end else if (tick & (run_r | timer)) begin
        if (count_r == 16'h0000) begin
          zero_r  <= 1'b1;   // R15
          count_r <= preset; // R12
          sq_r    <= ~sq_r;  // R13
          // single delay: counter and time-out stop after one pass
          if (!timer) begin
            run_r <= 1'b0;   // R13
          end
        end else begin
          count_r <= count_r - 16'h0001; // R15
        end
      end
    end
  end
endmodule // dti_ct

/* design/dti_timing_irq.v */
`timescale 1ns/1ps
`include "dti_regs.vh"

// Function
// R1 - host spaces same-register writes by three oscillator edges
// R2 - one active-low interrupt from eight sources
// R3 - only mask-enabled sources drive the interrupt
// R4 - status read shows all active sources, unmasked
// R5 - status holds one combined level-change bit
// R6 - per-input change interrupt enabled by auxiliary control
// R7 - upper output bits carry discrete interrupts/DMA
// R8 - eighteen fixed baud rates from oscillator
// R9 - generator clocks run at sixteen times baud
// R10 - counter/timer makes arbitrary 16x clock
// R11 - four selectors pick rate, counter or external
// R12 - 16-bit divider reloading from preset registers
// R13 - timer square wave, counter single delay
// R14 - receiver starts/stops counter in time-out mode
// R15 - counts down, status bit at every zero
// R16 - counter output to pin or clock source
// R17 - six counter/timer commands; the code decodes five (start, stop, load, time-out on, time-out off)
// R18 - read 0xD gives seven pins, top bit one
// R19 - four detectors set change bits on transitions
// R20 - reading change register clears change bits
// R21 - level change may raise an interrupt
// R22 - 38.4 kHz sampling, two samples at new level
// R23 - interrupt low exactly when status AND mask nonzero
module dti_timing_irq (
  input  wire       core_clk,          // system clock, 100 MHz
  input  wire       rst_b,             // async reset, active low
  input  wire       osc_in,            // oscillator pin, 3.6864 MHz
  input  wire [3:0] bus_addr,          // register address pins
  input  wire       bus_ce_b,          // chip enable, active low
  input  wire       bus_rd_b,          // read strobe, active low
  input  wire       bus_wr_b,          // write strobe, active low
  input  wire [7:0] bus_data_in,       // data bus, pin level
  output wire [7:0] bus_data_out,      // data bus, driven value
  output reg        bus_data_oe,       // data bus drive enable
  input  wire [6:0] input_pins,        // seven-bit input port
  input  wire       ext_clk_rxa,       // external timing, receiver a
  input  wire       ext_clk_txa,       // external timing, transmitter a
  input  wire       ext_clk_rxb,       // external timing, receiver b
  input  wire       ext_clk_txb,       // external timing, transmitter b
  input  wire       src_tx_rdy_a,      // transmitter a ready
  input  wire       src_rx_rdy_a,      // receiver a ready
  input  wire       src_break_a,       // delta break a
  input  wire       src_tx_rdy_b,      // transmitter b ready
  input  wire       src_rx_rdy_b,      // receiver b ready
  input  wire       src_break_b,       // delta break b
  input  wire       rx_to_start,       // receiver restarts time-out
  input  wire       rx_to_stop,        // receiver stops time-out
  output reg        irq_n_out,         // interrupt, active low
  output wire       clk16_rxa,         // 16x strobe, receiver a
  output wire       clk16_txa,         // 16x strobe, transmitter a
  output wire       clk16_rxb,         // 16x strobe, receiver b
  output wire       clk16_txb,         // 16x strobe, transmitter b
  output wire       ct_out,            // counter/timer square wave
  output reg  [4:0] upper_output_bits, // upper port levels
  output reg  [4:0] upper_output_oe    // upper port drive enables
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg  [26:0] sync1_r;
  reg  [26:0] sync2_r;
  // first stage is read only by the second stage
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= `DTI_RST_SYNC;
      sync2_r <= `DTI_RST_SYNC;
    end else begin
      sync1_r <= {osc_in, bus_ce_b, bus_rd_b, bus_wr_b, bus_addr, bus_data_in,
                  input_pins, ext_clk_txb, ext_clk_rxb, ext_clk_txa, ext_clk_rxa};
      sync2_r <= sync1_r;
    end
  end
  wire       osc_s  = sync2_r[26];
  wire       rd_act = ~sync2_r[25] & ~sync2_r[24];
  wire       wr_act = ~sync2_r[25] & ~sync2_r[23];
  wire [3:0] addr_s = sync2_r[22:19];
  wire [7:0] din_s  = sync2_r[18:11];
  wire [6:0] pins_s = sync2_r[10:4];
  wire [3:0] ext_s  = sync2_r[3:0];

  // ----------------------------------------
  // edge detection and bus cycle tracking
  // ----------------------------------------
  reg        osc_q_r;
  reg  [3:0] ext_q_r;
  reg        ip2_q_r;
  reg        rd_q_r;
  reg        wr_q_r;
  reg  [3:0] cyc_addr_r;
  reg  [7:0] wdata_r;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_q_r    <= 1'b0;
      ext_q_r    <= 4'h0;
      ip2_q_r    <= 1'b1;
      rd_q_r     <= 1'b0;
      wr_q_r     <= 1'b0;
      cyc_addr_r <= 4'h0;
      wdata_r    <= `DTI_RST_BYTE;
    end else begin
      osc_q_r <= osc_s;
      ext_q_r <= ext_s;
      ip2_q_r <= pins_s[2];
      rd_q_r  <= rd_act;
      wr_q_r  <= wr_act;
      // data and address are held from the last cycle of the strobe
      if (rd_act | wr_act) begin
        cyc_addr_r <= addr_s;
      end
      if (wr_act) begin
        wdata_r <= din_s;
      end
    end
  end
  wire       osc_tick = osc_s & ~osc_q_r;
  wire [3:0] ext_rise = ext_s & ~ext_q_r;
  wire       ip2_rise = pins_s[2] & ~ip2_q_r;
  // writes commit at the trailing edge of the strobe
  wire       wr_end   = wr_q_r & ~wr_act;
  wire       rd_end   = rd_q_r & ~rd_act;
  wire       cmd_wr   = wr_end & (cyc_addr_r == `DTI_OFF_CMD); // R1
  wire       cmd_st   = cmd_wr & (wdata_r == `DTI_CMD_START);   // R17
  wire       cmd_sp   = cmd_wr & (wdata_r == `DTI_CMD_STOP);    // R17
  wire       cmd_ld   = cmd_wr & (wdata_r == `DTI_CMD_LOAD);    // R17

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  reg  [4:0] sel_r [0:3];
  reg  [7:0] aux_r;
  reg  [7:0] imr_r;
  reg  [7:0] pre_hi_r;
  reg  [7:0] pre_lo_r;
  reg        to_mode_r;
  reg  [4:0] opcfg_r;
  integer    k;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (k = 0; k < 4; k = k + 1) begin
        sel_r[k] <= `DTI_RST_SEL;
      end
      aux_r     <= `DTI_RST_BYTE;
      imr_r     <= `DTI_RST_BYTE;
      pre_hi_r  <= `DTI_RST_BYTE;
      pre_lo_r  <= `DTI_RST_BYTE;
      to_mode_r <= 1'b0;
      opcfg_r   <= 5'h00;
    end else if (wr_end) begin
      if (cyc_addr_r[3:2] == 2'h0) begin
        sel_r[cyc_addr_r[1:0]] <= wdata_r[4:0]; // R11
      end else if (cyc_addr_r == `DTI_OFF_AUX) begin
        aux_r <= wdata_r; // R6
      end else if (cyc_addr_r == `DTI_OFF_IRQ) begin
        imr_r <= wdata_r; // R3
      end else if (cyc_addr_r == `DTI_OFF_PRE_HI) begin
        pre_hi_r <= wdata_r; // R17
      end else if (cyc_addr_r == `DTI_OFF_PRE_LO) begin
        pre_lo_r <= wdata_r; // R17
      end else if (cyc_addr_r == `DTI_OFF_OPCFG) begin
        opcfg_r <= wdata_r[4:0]; // R7
      end else if (cyc_addr_r == `DTI_OFF_CMD) begin
        if (wdata_r == `DTI_CMD_TO_ON) begin
          to_mode_r <= 1'b1; // R17
        end else if (wdata_r == `DTI_CMD_TO_OFF) begin
          to_mode_r <= 1'b0; // R17
        end
      end
    end
  end

  // ----------------------------------------
  // counter/timer
  // ----------------------------------------
  wire [15:0] ct_count;
  wire        ct_zero;
  wire        ct_sq;
  // external source is the rising edge of input pin 2
  wire        ct_tick = aux_r[`DTI_AUX_EXT_BIT] ? ip2_rise : osc_tick; // R10
  dti_ct u_ct (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .tick      (ct_tick),
    .mode      (aux_r[5:4]),
    .to_mode   (to_mode_r),
    .preset    ({pre_hi_r, pre_lo_r}),
    .cmd_start (cmd_st),
    .cmd_stop  (cmd_sp),
    .cmd_load  (cmd_ld),
    .rx_start  (rx_to_start),
    .rx_stop   (rx_to_stop),
    .count_r   (ct_count),
    .zero_r    (ct_zero),
    .sq_r      (ct_sq)
  );
  assign ct_out = ct_sq; // R16
  // one 16x strobe per full square-wave period
  wire ct_clk = ct_zero & ct_sq; // R10

  // ----------------------------------------
  // rate generator and clock selectors
  // ----------------------------------------
  function [12:0] baud_div;
    input [4:0] s;
    reg   [31:0] b;
    reg   [31:0] q;
    begin
      case (s)
        5'h00:   b = 32'h0000_0032;
        5'h01:   b = 32'h0000_004b;
        5'h02:   b = 32'h0000_006e;
        5'h03:   b = 32'h0000_0096;
        5'h04:   b = 32'h0000_00c8;
        5'h05:   b = 32'h0000_012c;
        5'h06:   b = 32'h0000_0258;
        5'h07:   b = 32'h0000_041a;
        5'h08:   b = 32'h0000_04b0;
        5'h09:   b = 32'h0000_0708;
        5'h0a:   b = 32'h0000_07d0;
        5'h0b:   b = 32'h0000_0960;
        5'h0c:   b = 32'h0000_12c0;
        5'h0d:   b = 32'h0000_1c20;
        5'h0e:   b = 32'h0000_2580;
        5'h0f:   b = 32'h0000_4b00;
        5'h10:   b = 32'h0000_9600;
        default: b = 32'h0001_c200;
      endcase
      q = `DTI_OSC_HZ / (`DTI_BAUD_MULT * b); // R9
      baud_div = q[12:0];
    end
  endfunction

  wire [3:0] clk16;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sel
      reg  [12:0] div_r;
      reg         out_r;
      wire [12:0] div_end = baud_div(sel_r[g]) - 13'h0001;
      // each selector keeps its own divider so four rates run at once
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          div_r <= 13'h0000;
          out_r <= 1'b0;
        end else begin
          out_r <= 1'b0;
          if (sel_r[g] < `DTI_SEL_RATES) begin
            if (osc_tick) begin
              if (div_r >= div_end) begin
                div_r <= 13'h0000;
                out_r <= 1'b1; // R8
              end else begin
                div_r <= div_r + 13'h0001;
              end
            end
          end else if (sel_r[g] == `DTI_SEL_CT) begin
            out_r <= ct_clk; // R16
          end else if (sel_r[g] == `DTI_SEL_EXT) begin
            out_r <= ext_rise[g]; // R11
          end
        end
      end
      assign clk16[g] = out_r;
    end
  endgenerate
  assign clk16_rxa = clk16[0];
  assign clk16_txa = clk16[1];
  assign clk16_rxb = clk16[2];
  assign clk16_txb = clk16[3];

  // ----------------------------------------
  // change-of-state detectors
  // ----------------------------------------
  reg  [6:0] smp_cnt_r;
  reg        smp_r;
  reg        primed_r;
  reg  [3:0] chg_r;
  wire [31:0] smp_end = `DTI_CHG_DIV - 32'h0000_0001;
  wire       chg_rd  = rd_end & (cyc_addr_r == `DTI_OFF_CHG);
  // sampling strobe comes from its own divider of the oscillator ticks
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      smp_cnt_r <= 7'h00;
      smp_r     <= 1'b0;
      primed_r  <= 1'b0;
    end else begin
      smp_r <= 1'b0;
      if (osc_tick) begin
        if (smp_cnt_r >= smp_end) begin
          smp_cnt_r <= 7'h00;
          smp_r     <= 1'b1; // R22
        end else begin
          smp_cnt_r <= smp_cnt_r + 7'h01;
        end
      end
      if (smp_r) begin
        primed_r <= 1'b1;
      end
    end
  end

  wire [3:0] level;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chg
      reg stable_r;
      reg pend_r;
      // first sample after reset only seeds the level, so pull-ups
      // do not report a false change
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          stable_r <= 1'b0;
          pend_r   <= 1'b0;
          chg_r[g] <= 1'b0;
        end else begin
          if (smp_r & ~primed_r) begin
            stable_r <= pins_s[g];
          end else if (smp_r & (pins_s[g] != stable_r)) begin
            pend_r <= ~pend_r; // R22
            if (pend_r) begin
              stable_r <= pins_s[g];
            end
          end else if (smp_r) begin
            pend_r <= 1'b0;
          end
          // a change landing with the read is kept: set wins
          if (smp_r & primed_r & pend_r & (pins_s[g] != stable_r)) begin
            chg_r[g] <= 1'b1; // R19
          end else if (chg_rd) begin
            chg_r[g] <= 1'b0; // R20
          end
        end
      end
      assign level[g] = stable_r;
    end
  endgenerate

  // ----------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------
  reg        ct_rdy_r;
  wire       chg_any = |(chg_r & aux_r[3:0]); // R5 R6 R21
  wire [7:0] irq_status_reg = {chg_any, src_break_b, src_rx_rdy_b, src_tx_rdy_b,
                    ct_rdy_r, src_break_a, src_rx_rdy_a, src_tx_rdy_a}; // R2
  wire [4:0] up_cond = {src_tx_rdy_b, src_tx_rdy_a, src_rx_rdy_b,
                        src_rx_rdy_a, ct_rdy_r};
  // counter ready is sticky until a stop command; a zero pass wins
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ct_rdy_r          <= 1'b0;
      irq_n_out         <= 1'b1;
      upper_output_bits <= 5'h1f;
      upper_output_oe   <= 5'h00;
    end else begin
      if (ct_zero) begin
        ct_rdy_r <= 1'b1; // R15
      end else if (cmd_sp) begin
        ct_rdy_r <= 1'b0;
      end
      irq_n_out         <= ~|(irq_status_reg & imr_r); // R23 R3
      // open drain: pull low only while the condition is active
      upper_output_bits <= ~(opcfg_r & up_cond); // R7
      upper_output_oe   <= opcfg_r & up_cond;    // R7
    end
  end

  // ----------------------------------------
  // read data path
  // ----------------------------------------
  reg [7:0] rdata_nxt;
  reg [7:0] rdata_r;
  always @* begin
    if (addr_s[3:2] == 2'h0) begin
      rdata_nxt = {3'h0, sel_r[addr_s[1:0]]};
    end else if (addr_s == `DTI_OFF_AUX) begin
      rdata_nxt = aux_r;
    end else if (addr_s == `DTI_OFF_IRQ) begin
      rdata_nxt = irq_status_reg; // R4
    end else if (addr_s == `DTI_OFF_PRE_HI) begin
      rdata_nxt = ct_count[15:8]; // R17
    end else if (addr_s == `DTI_OFF_PRE_LO) begin
      rdata_nxt = ct_count[7:0]; // R17
    end else if (addr_s == `DTI_OFF_CHG) begin
      rdata_nxt = {level, chg_r};
    end else if (addr_s == `DTI_OFF_OPCFG) begin
      rdata_nxt = {3'h0, opcfg_r};
    end else if (addr_s == `DTI_OFF_INPORT) begin
      rdata_nxt = {`DTI_INPORT_TOP, pins_s}; // R18
    end else begin
      rdata_nxt = 8'h00;
    end
  end
  // data held in a flop and driven only while the read strobe is seen
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r     <= `DTI_RST_BYTE;
      bus_data_oe <= 1'b0;
    end else begin
      rdata_r     <= rdata_nxt;
      bus_data_oe <= rd_act;
    end
  end
  assign bus_data_out = rdata_r;
endmodule // dti_timing_irq

/* test/dti_timing_irq_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module dti_chk (
  input wire       core_clk,          // clock
  input wire       rst_b,             // reset
  input wire [3:0] bus_addr,          // address
  input wire       bus_ce_b,          // chip enable
  input wire       bus_rd_b,          // read strobe
  input wire [7:0] bus_data_out,      // read data
  input wire       bus_data_oe,       // data drive
  input wire       irq_n_out,         // interrupt
  input wire       clk16_rxa,         // strobe rxa
  input wire       clk16_txb,         // strobe txb
  input wire       ct_out,            // square wave
  input wire [4:0] upper_output_bits, // port levels
  input wire [4:0] upper_output_oe    // port enables
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // the bus is driven only once a read has crossed the synchroniser
  oe_after_read_a: assert property (bus_data_oe |->
    !$past(bus_ce_b, 3) && !$past(bus_rd_b, 3))
    else $error("data bus driven without a read");
  idle_undriven_a: assert property (bus_rd_b [*3] |=> !bus_data_oe)
    else $error("data bus driven while idle");
  inport_top_a: assert property (
    bus_data_oe && $past(bus_addr, 3) == 4'hd && $past(bus_addr, 2) == 4'hd |-> bus_data_out[7])
    else $error("input port top bit not one");
  reset_idle_a: assert property ($rose(rst_b) |-> irq_n_out && upper_output_bits == 5'h1f)
    else $error("outputs not idle after reset");
  rxa_pulse_a: assert property (clk16_rxa |=> !clk16_rxa [*8])
    else $error("rxa strobe too dense");
  txb_gap_a: assert property ($rose(clk16_txb) |=> $fell(clk16_txb) ##1 !clk16_txb [*6])
    else $error("txb strobe too long");
  ct_steady_a: assert property ($changed(ct_out) |=> $stable(ct_out) [*8])
    else $error("square wave toggles too fast");
  // open drain: an enabled bit may only pull low
  open_drain_a: assert property ((upper_output_oe & upper_output_bits) == 5'h00)
    else $error("upper port drives high");
  cover property (bus_data_oe && bus_addr == 4'hd);
  cover property ($fell(irq_n_out));
  cover property ($rose(ct_out));
endmodule // dti_chk

bind dti_timing_irq dti_chk u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_ce_b(bus_ce_b),
  .bus_rd_b(bus_rd_b), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
  .irq_n_out(irq_n_out), .clk16_rxa(clk16_rxa), .clk16_txb(clk16_txb), .ct_out(ct_out),
  .upper_output_bits(upper_output_bits), .upper_output_oe(upper_output_oe)
);

/* test/dti_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// host side of the register bus
// ----------------------------------------
module dti_host (
  input  wire       core_clk,     // clock
  output reg  [3:0] bus_addr,     // address pins
  output reg        bus_ce_b,     // chip enable
  output reg        bus_rd_b,     // read strobe
  output reg        bus_wr_b,     // write strobe
  output wire [7:0] bus_data_in,  // data pin level
  input  wire [7:0] bus_data_out, // device data
  input  wire       bus_data_oe   // device drives
);
  reg [7:0] drv_r;    // write value
  reg       drv_on_r; // host drives the pins
  reg [7:0] last_r;   // last pin level
  integer   n;
  // no pull on the data bus, so a released bus must not hold its value
  assign bus_data_in = bus_data_oe ? bus_data_out : (drv_on_r ? drv_r : ~last_r);
  always @(posedge core_clk) last_r <= bus_data_in;
  initial begin
    bus_addr = 4'h0;
    bus_ce_b = 1'b1;
    bus_rd_b = 1'b1;
    bus_wr_b = 1'b1;
    drv_r = 8'h00;
    drv_on_r = 1'b0;
    last_r = 8'h00;
  end
  // write: strobe low six cycles, then a long gap
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      bus_addr <= a;
      drv_r <= d;
      drv_on_r <= 1'b1;
      bus_ce_b <= 1'b0;
      bus_wr_b <= 1'b0;
      repeat (6) @(posedge core_clk);
      bus_ce_b <= 1'b1;
      bus_wr_b <= 1'b1;
      drv_on_r <= 1'b0;
      repeat (50) @(posedge core_clk);
    end
  endtask
  // read: hold the strobe until the device drives, take data at that edge
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge core_clk);
      bus_addr <= a;
      bus_ce_b <= 1'b0;
      bus_rd_b <= 1'b0;
      n = 0;
      do begin
        @(posedge core_clk);
        n = n + 1;
      end while (bus_data_oe !== 1'b1 && n < 20);
      d = bus_data_out;
      bus_ce_b <= 1'b1;
      bus_rd_b <= 1'b1;
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule // dti_host

/* test/testbench.sv */
`timescale 1ns/1ps
`include "dti_regs.vh"
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module testbench;
  reg        core_clk, rst_b, osc_in, ext_clk_rxb;
  reg  [6:0] input_pins;
  reg  [5:0] src;
  wire [3:0] bus_addr;
  wire       bus_ce_b, bus_rd_b, bus_wr_b, bus_data_oe, irq_n_out;
  wire [7:0] bus_data_in, bus_data_out;
  wire       clk16_rxa, clk16_txa, clk16_rxb, clk16_txb, ct_out;
  wire [4:0] upper_output_bits, upper_output_oe;
  integer    errors, checked, cyc, i, n0, n1, n2;
  integer    n_rxa = 0, n_rxb = 0, n_txb = 0;
  reg [31:0] seed, r;
  reg [7:0]  rd_v, m;
  dti_host u_host (.core_clk(core_clk), .bus_addr(bus_addr), .bus_ce_b(bus_ce_b),
    .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe));
  dti_timing_irq dut (.core_clk(core_clk), .rst_b(rst_b), .osc_in(osc_in),
    .bus_addr(bus_addr), .bus_ce_b(bus_ce_b), .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b),
    .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .input_pins(input_pins), .ext_clk_rxa(1'b0), .ext_clk_txa(1'b0),
    .ext_clk_rxb(ext_clk_rxb), .ext_clk_txb(1'b0), .src_tx_rdy_a(src[0]),
    .src_rx_rdy_a(src[1]), .src_break_a(src[2]), .src_tx_rdy_b(src[3]),
    .src_rx_rdy_b(src[4]), .src_break_b(src[5]), .rx_to_start(1'b0), .rx_to_stop(1'b0),
    .irq_n_out(irq_n_out), .clk16_rxa(clk16_rxa), .clk16_txa(), .clk16_rxb(clk16_rxb),
    .clk16_txb(clk16_txb), .ct_out(ct_out), .upper_output_bits(upper_output_bits),
    .upper_output_oe(upper_output_oe));
  function [31:0] xs(input dummy);
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  // sources land in status bits 0-2 and 4-6
  function [7:0] stat(input [5:0] s);
    stat = {1'b0, s[5:3], 1'b0, s[2:0]};
  endfunction
  task check(input [15:0] seen, input [15:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // oscillator unrelated in phase to the core clock
  initial begin
    osc_in = 1'b0;
    forever #135.634 osc_in = ~osc_in;
  end
  // strobe counters and the hang limit
  always @(posedge core_clk) begin
    n_rxa <= n_rxa + clk16_rxa;
    n_rxb <= n_rxb + clk16_rxb;
    n_txb <= n_txb + clk16_txb;
    cyc = cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  initial begin
    seed = 32'h88dc;
    errors = 0;
    checked = 0;
    cyc = 0;
    #1 rst_b = 1'b0;
    ext_clk_rxb = 1'b0;
    input_pins = 7'h7f;
    src = 6'h00;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    check({irq_n_out, bus_data_oe, upper_output_bits, upper_output_oe}, 12'hbe0);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      r = xs(1'b0);
      @(posedge core_clk);
      input_pins <= r[6:0];
      u_host.rd(`DTI_OFF_INPORT, rd_v);
      check(rd_v, {1'b1, r[6:0]});
    end
    $display("input port test done");
    // rounds 0-1: sources all masked, then all enabled but idle
    for (i = 0; i < 8; i = i + 1) begin
      r = (i == 0) ? 32'h0000_003f : (i == 1) ? 32'h0000_7700 : xs(1'b0);
      m = r[15:8] & 8'h77;
      @(posedge core_clk);
      src <= r[5:0];
      u_host.wr(`DTI_OFF_IRQ, m);
      u_host.rd(`DTI_OFF_IRQ, rd_v);
      check(rd_v & 8'h77, stat(r[5:0]));
      check(irq_n_out, ~|(stat(r[5:0]) & m));
    end
    $display("interrupt test done");
    @(posedge core_clk);
    src <= 6'h00;
    input_pins <= 7'h0a;
    u_host.wr(`DTI_OFF_AUX, 8'h0f);
    u_host.wr(`DTI_OFF_IRQ, 8'h80);
    repeat (7000) @(posedge core_clk);
    u_host.rd(`DTI_OFF_CHG, rd_v);
    // pin0 rises for good, pin1 dips under one sample
    input_pins <= 7'h0b;
    repeat (100) @(posedge core_clk);
    input_pins <= 7'h09;
    repeat (200) @(posedge core_clk);
    input_pins <= 7'h0b;
    repeat (7000) @(posedge core_clk);
    check(irq_n_out, 1'b0);
    u_host.rd(`DTI_OFF_IRQ, rd_v);
    check(rd_v & 8'h80, 8'h80);
    u_host.rd(`DTI_OFF_CHG, rd_v);
    check(rd_v, 8'hb1);
    u_host.rd(`DTI_OFF_CHG, rd_v);
    check(rd_v, 8'hb0);
    check(irq_n_out, 1'b1);
    $display("change detect test done");
    u_host.wr(`DTI_OFF_AUX, 8'h10);
    u_host.wr(`DTI_OFF_PRE_HI, 8'h00);
    u_host.wr(`DTI_OFF_PRE_LO, 8'h04);
    u_host.wr(`DTI_OFF_SEL_RXA, 8'h12);
    u_host.wr(`DTI_OFF_SEL_TXB, 8'h11);
    u_host.wr(`DTI_OFF_SEL_RXB, 8'h13);
    u_host.wr(`DTI_OFF_OPCFG, 8'h01);
    u_host.wr(`DTI_OFF_IRQ, 8'h08);
    u_host.wr(`DTI_OFF_CMD, `DTI_CMD_START);
    n0 = n_rxa;
    n1 = n_txb;
    n2 = n_rxb;
    // 100 osc periods, ten external rises
    for (i = 0; i < 20; i = i + 1) begin
      repeat (135) @(posedge core_clk);
      ext_clk_rxb <= ~ext_clk_rxb;
    end
    repeat (13) @(posedge core_clk);
    check(n_txb - n1 >= 49 && n_txb - n1 <= 51, 1'b1);
    check(n_rxa - n0 >= 9 && n_rxa - n0 <= 13, 1'b1);
    check(n_rxb - n2, 16'h000a);
    check(irq_n_out, 1'b0);
    check({upper_output_bits[0], upper_output_oe[0]}, 2'b01);
    u_host.rd(`DTI_OFF_PRE_LO, rd_v);
    check(rd_v <= 8'h04, 1'b1);
    u_host.wr(`DTI_OFF_AUX, 8'h00);
    u_host.wr(`DTI_OFF_CMD, `DTI_CMD_STOP);
    u_host.rd(`DTI_OFF_IRQ, rd_v);
    check(rd_v & 8'h08, 8'h00);
    check(irq_n_out, 1'b1);
    $display("counter timer test done");
    complete_run;
  end
endmodule // testbench
